// ### test/pfc_conv_monitor.sv
// Port checker for the parallel feedback converter
`timescale 1ns/1ns
`default_nettype none
module pfc_conv_monitor
   import pfc_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         servo_tick,
   input wire pfc_apb_req_s apb_req,
   input wire pfc_apb_rsp_s apb_rsp,
   input wire pfc_mem_req_s mem_req,
   input wire pfc_mem_rsp_s mem_rsp,
   input wire logic         busy,
   input wire logic         pass_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   a_apb_answer: assert property (
      apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("apb access not answered");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   a_err_clean: assert property (
      apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error response carries data");
   // Space and address must not move under a pending fetch
   a_req_hold: assert property (
      mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req))
      else $error("fetch request changed before ack");
   a_req_release: assert property (mem_req.req && mem_rsp.ack |=> !mem_req.req)
      else $error("fetch request held after ack");
   a_req_gap: assert property ($fell(mem_req.req) |-> ##1 !mem_req.req)
      else $error("fetch requests too close");
   a_done_ends: assert property (
      pass_done |-> !busy ##1 !pass_done)
      else $error("pass end pulse malformed");
   a_busy_cause: assert property ($rose(busy) |-> $past(servo_tick))
      else $error("pass started without tick");
endmodule
bind pfc_conv pfc_conv_monitor mon (.clk(clk), .rst_n(rst_n),
   .servo_tick(servo_tick), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy),
   .pass_done(pass_done));
`default_nettype wire

// ### test/pfc_src_model.sv
// Source word memory answering the converter's fetches
`timescale 1ns/1ns
`default_nettype none
module pfc_src_model
   import pfc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire pfc_mem_req_s mem_req,
   output var  pfc_mem_rsp_s mem_rsp
);
   logic [23:0] ymem [16];
   logic [23:0] xmem [16];
   logic [2:0]  wait_cnt;
   logic        slow;
   // Alternates prompt and slow answers; data lines toggle when idle
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         mem_rsp  <= '0;
         wait_cnt <= 3'h0;
         slow     <= 1'b0;
      end
      else if (mem_req.req && !mem_rsp.ack && wait_cnt == {slow, 2'h0})
      begin
         mem_rsp.ack   <= 1'b1;
         mem_rsp.rdata <= mem_req.space_x ? xmem[mem_req.addr[3:0]]
                                          : ymem[mem_req.addr[3:0]];
         wait_cnt      <= 3'h0;
         slow          <= ~slow;
      end
      else
      begin
         mem_rsp.ack   <= 1'b0;
         mem_rsp.rdata <= ~mem_rsp.rdata;
         wait_cnt      <= (mem_req.req && !mem_rsp.ack) ? wait_cnt + 3'h1
                                                        : 3'h0;
      end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the parallel feedback converter
`timescale 1ns/1ns
`default_nettype none
module tb
   import pfc_pkg::*;
;
   logic         clk;
   logic         rst_n;
   logic         servo_tick;
   logic         busy;
   logic         pass_done;
   pfc_apb_req_s apb_req;
   pfc_apb_rsp_s apb_rsp;
   pfc_mem_req_s mem_req;
   pfc_mem_rsp_s mem_rsp;
   int           error_cnt = 0;
   int           n_compared = 0;
   int           cyc = 0;
   logic [31:0]  rd;
   logic         er;
   logic [23:0]  setup [11] = '{24'h200001, 24'h000FFF, 24'h680002,
      24'hFFFFFF, 24'h210003, 24'h000FFF, 24'h300004, 24'h000FFF,
      24'h000004, 24'h180005, 24'h100005};
   pfc_conv dut (.clk(clk), .rst_n(rst_n), .servo_tick(servo_tick),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .mem_req(mem_req),
      .mem_rsp(mem_rsp), .busy(busy), .pass_done(pass_done));
   pfc_src_model src (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
      .mem_rsp(mem_rsp));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do
         @(posedge clk);
      while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [23:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, {8'h00, e});
   endtask
   task automatic pass();
      @(posedge clk);
      servo_tick <= 1'b1;
      @(posedge clk);
      servo_tick <= 1'b0;
      while (pass_done !== 1'b1)
         @(posedge clk);
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Whole run needs well under this many cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      logic [23:0] ext, r2, r3, fx, tgt;
      rst_n = 1'b0;
      servo_tick = 1'b0;
      apb_req = '0;
      r2 = 24'($urandom(32'h89F0));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, PFC_REG_STAT, 32'hFFFF);
      chk({31'h0, er}, 32'h1);
      $display("test refusals done");
      r2 = 24'($urandom_range(24'h7FFFFF));
      r3 = 24'($urandom_range(2047));
      ext = 24'($urandom_range(2047));
      fx = 24'h0;
      tgt = 24'h0;
      src.xmem[2] = r2;
      src.ymem[2] = ~r2;
      src.ymem[3] = {12'hABC, r3[11:0]};
      src.ymem[5] = 24'h8000A5;
      for (int i = 0; i < 11; i++)
         apb(1'b1, 12'h100 + 12'(4 * i), {8'h00, setup[i]});
      apb(1'b1, PFC_REG_CTRL, 32'h00000B01);
      rchk(PFC_REG_CTRL, 24'h000B01);
      // Source moves up to half the mask range, so it wraps often
      for (int p = 0; p < 6; p++)
      begin
         src.ymem[1] = {12'($urandom), ext[11:0]};
         src.ymem[4] = {12'hC00, tgt[11:0]};
         fx = (tgt - fx > 24'h4) ? fx + 24'h4 : tgt;
         pass();
         rchk(12'h204, ext << 5);
         rchk(12'h20C, r2);
         rchk(12'h214, (r3 << 5) + r2);
         rchk(12'h218, tgt << 5);
         rchk(12'h220, fx << 5);
         rchk(12'h224, 24'h100000);
         rchk(12'h228, 24'hF00000);
         ext = ext + 24'($urandom_range(2047));
         tgt = 24'h14;
         $display("test pass %0d done", p);
      end
      apb(1'b0, PFC_REG_STAT, 32'h0);
      chk({16'h0, rd[31:16]}, 32'h6);
      test_done();
   end
endmodule
`default_nettype wire

// ### verilog/pfc_conv.sv
// Parallel feedback converter: table walker with APB setup access
`timescale 1ns/1ns
`default_nettype none

module pfc_conv
   import pfc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         servo_tick,
   input  wire pfc_apb_req_s apb_req,
   output var  pfc_apb_rsp_s apb_rsp,
   output var  pfc_mem_req_s mem_req,
   input  wire pfc_mem_rsp_s mem_rsp,
   output logic              busy,
   output logic              pass_done
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [PFC_DEPTH-1:0][PFC_DW-1:0] y_tbl;
      logic [PFC_DEPTH-1:0][PFC_DW-1:0] x_tbl;
      pfc_state_e                       st;
      logic [4:0]                       idx;
      logic [4:0]                       cnt;
      logic                             enable;
      logic [PFC_DW-1:0]                prev_res;
      logic [PFC_DW-1:0]                src;
      logic [15:0]                      passes;
      pfc_apb_rsp_s                     rsp;
      pfc_mem_req_s                     mreq;
      logic                             busy;
      logic                             done;
   } pfc_regs_s;

   pfc_regs_s s;
   pfc_regs_s next_s;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [7:0]        fmt;
      logic [3:0]        fam;
      logic [PFC_IW-1:0] i0;
      logic [PFC_IW-1:0] i1;
      logic [PFC_IW-1:0] i2;
      logic [PFC_IW-1:0] ai;
      logic              unsh;
      logic              filt;
      logic [23:0]       mask;
      logic [23:0]       raw;
      logic [23:0]       rd;
      logic [23:0]       ms;
      logic [23:0]       base;
      logic [23:0]       dm;
      logic [23:0]       top;
      logic [23:0]       ext;
      logic [23:0]       ds;
      logic [23:0]       mag;
      logic [23:0]       lim;
      logic [23:0]       pos;
      logic [23:0]       res;
      logic [15:0]       an;
      logic              neg;
      logic              acc;
      logic              pg_y;
      logic              pg_x;
      logic              tbl_ok;
      logic [31:0]       rdat;
      logic              err;

      next_s = s;
      fmt    = s.y_tbl[s.idx[PFC_IW-1:0]][PFC_FMT_HI:PFC_FMT_LO];
      fam    = fmt[7:4];
      unsh   = fmt[PFC_UNSH_BIT];
      filt   = fmt[PFC_FILT_BIT];
      i0     = s.idx[PFC_IW-1:0];
      i1     = 4'(s.idx + PFC_STEP1);
      i2     = 4'(s.idx + PFC_STEP2);
      ai     = apb_req.paddr[5:2];
      mask   = s.y_tbl[i1];
      raw    = s.src & mask;
      // Bits above 18 fall off the top in shifted mode
      rd     = unsh ? raw : {raw[18:0], 5'h00};
      ms     = unsh ? mask : {mask[18:0], 5'h00};
      base   = filt ? s.x_tbl[i1] : s.x_tbl[i0];
      dm     = 24'(rd - (base & ms)) & ms;
      // Highest mask bit marks the sign of a wrapped difference
      top    = ms & ~(ms >> 1);
      neg    = |(dm & top);
      ext    = ~ms & ~(unsh ? PFC_ZERO24 : PFC_FRAC_MASK);
      ds     = neg ? (dm | ext) : dm;
      mag    = neg ? 24'(-ds) : ds;
      lim    = unsh ? s.y_tbl[i2] : {s.y_tbl[i2][18:0], 5'h00};
      if (filt && (mag > lim))
      begin
         // Clamped against the filtered value, so the rest follows later
         ds = neg ? 24'(-lim) : lim;
      end
      pos    = 24'(base + ds);
      res    = 24'(pos + (fmt[PFC_SUM_BIT] ? s.prev_res : PFC_ZERO24));
      an     = s.src[PFC_DW-1:PFC_AN_LO];
      acc    = apb_req.psel && apb_req.penable && !s.rsp.pready;
      pg_y   = apb_req.paddr[11:8] == PFC_PAGE_Y;
      pg_x   = apb_req.paddr[11:8] == PFC_PAGE_X;
      tbl_ok = (apb_req.paddr[7:6] == 2'b00)
               && (apb_req.paddr[1:0] == 2'b00);
      rdat   = 32'h00000000;
      err    = 1'b0;

      next_s.done = 1'b0;

      // Engine
      unique case (s.st)
         PFC_ST_IDLE:
         begin
            if (servo_tick && s.enable)
            begin
               next_s.st   = PFC_ST_DECODE;
               next_s.idx  = PFC_CNT_RST;
               next_s.busy = 1'b1;
            end
         end
         PFC_ST_DECODE:
         begin
            if (s.idx >= s.cnt)
            begin
               next_s.st     = PFC_ST_IDLE;
               next_s.busy   = 1'b0;
               next_s.done   = 1'b1;
               next_s.passes = 16'(s.passes + 16'h0001);
            end
            else if ((fam == PFC_FAM_AN) || (fam == PFC_FAM_PY)
                     || (fam == PFC_FAM_PYF) || (fam == PFC_FAM_PX)
                     || (fam == PFC_FAM_PXF))
            begin
               next_s.st           = PFC_ST_FETCH;
               next_s.mreq.req     = 1'b1;
               next_s.mreq.space_x = fmt[PFC_SPACE_BIT];
               next_s.mreq.addr    = s.y_tbl[i0][PFC_ADDR_HI:0];
            end
            else
            begin
               // Unsupported entry types take one word and are skipped
               next_s.idx = 5'(s.idx + PFC_STEP1);
            end
         end
         PFC_ST_FETCH:
         begin
            if (mem_rsp.ack)
            begin
               next_s.mreq.req = 1'b0;
               next_s.src      = mem_rsp.rdata;
               next_s.st       = PFC_ST_CALC;
            end
         end
         PFC_ST_CALC:
         begin
            next_s.st = PFC_ST_DECODE;
            if (fam == PFC_FAM_AN)
            begin
               // Three top integer bits sign-extend in shifted mode, stay zero when unshifted; fraction stays zero
               next_s.x_tbl[i0] = {{3{an[15] & ~fmt[PFC_UNSH_BIT]}},
                                   an, 5'h00};
               next_s.prev_res  = next_s.x_tbl[i0];
               next_s.idx       = 5'(s.idx + PFC_STEP1);
            end
            else if (filt)
            begin
               next_s.x_tbl[i0] = rd;
               next_s.x_tbl[i1] = pos;
               next_s.x_tbl[i2] = res;
               next_s.prev_res  = res;
               next_s.idx       = 5'(s.idx + PFC_STEP3);
            end
            else
            begin
               next_s.x_tbl[i0] = pos;
               next_s.x_tbl[i1] = res;
               next_s.prev_res  = res;
               next_s.idx       = 5'(s.idx + PFC_STEP2);
            end
         end
      endcase

      // APB slave: one wait state, the write lands with pready
      next_s.rsp.pready  = acc;
      next_s.rsp.pslverr = 1'b0;
      if (acc)
      begin
         if (apb_req.paddr == PFC_REG_CTRL)
         begin
            rdat[PFC_CTRL_EN]            = s.enable;
            rdat[PFC_CNT_HI:PFC_CNT_LO]  = s.cnt;
            if (apb_req.pwrite)
            begin
               next_s.enable = apb_req.pwdata[PFC_CTRL_EN];
               next_s.cnt    = apb_req.pwdata[PFC_CNT_HI:PFC_CNT_LO];
            end
         end
         else if (apb_req.paddr == PFC_REG_STAT)
         begin
            rdat[PFC_CTRL_EN]           = s.busy;
            rdat[PFC_CNT_HI:PFC_CNT_LO] = s.idx;
            rdat[31:PFC_PASS_LO]        = s.passes;
            err                         = apb_req.pwrite;
         end
         else if (pg_y && tbl_ok)
         begin
            rdat[PFC_DW-1:0] = s.y_tbl[ai];
            if (apb_req.pwrite)
            begin
               next_s.y_tbl[ai] = apb_req.pwdata[PFC_DW-1:0];
            end
         end
         else if (pg_x && tbl_ok)
         begin
            rdat[PFC_DW-1:0] = s.x_tbl[ai];
            // Software write wins over the engine in the same cycle
            if (apb_req.pwrite)
            begin
               next_s.x_tbl[ai] = apb_req.pwdata[PFC_DW-1:0];
            end
         end
         else
         begin
            err = 1'b1;
         end
         // A refused access returns zero so no status leaks out
         next_s.rsp.prdata  = err ? 32'h00000000 : rdat;
         next_s.rsp.pslverr = err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s        <= '0;
         s.st     <= PFC_ST_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign apb_rsp   = s.rsp;
   assign mem_req   = s.mreq;
   assign busy      = s.busy;
   assign pass_done = s.done;

endmodule

`default_nettype wire

// ### verilog/pfc_pkg.sv
// Constants and types for the parallel feedback converter
package pfc_pkg;

   localparam int          PFC_DW        = 24;
   localparam int          PFC_DEPTH     = 16;
   localparam int          PFC_IW        = 4;

   // Register byte offsets and table page numbers
   localparam logic [11:0] PFC_REG_CTRL  = 12'h000;
   localparam logic [11:0] PFC_REG_STAT  = 12'h004;
   localparam logic [3:0]  PFC_PAGE_Y    = 4'h1;
   localparam logic [3:0]  PFC_PAGE_X    = 4'h2;

   // Field positions
   localparam int          PFC_CTRL_EN   = 0;
   localparam int          PFC_CNT_LO    = 8;
   localparam int          PFC_CNT_HI    = 12;
   localparam int          PFC_PASS_LO   = 16;
   localparam int          PFC_ADDR_HI   = 15;
   localparam int          PFC_FMT_LO    = 16;
   localparam int          PFC_FMT_HI    = 23;
   localparam int          PFC_AN_LO     = 8;
   localparam int          PFC_SHIFT     = 5;
   localparam int          PFC_UNSH_BIT  = 3;
   localparam int          PFC_FILT_BIT  = 4;
   localparam int          PFC_SUM_BIT   = 0;
   localparam int          PFC_SPACE_BIT = 6;

   // Format families (upper nibble of the format code)
   localparam logic [3:0]  PFC_FAM_AN    = 4'h1;
   localparam logic [3:0]  PFC_FAM_PY    = 4'h2;
   localparam logic [3:0]  PFC_FAM_PYF   = 4'h3;
   localparam logic [3:0]  PFC_FAM_PX    = 4'h6;
   localparam logic [3:0]  PFC_FAM_PXF   = 4'h7;

   localparam logic [4:0]  PFC_STEP1     = 5'h01;
   localparam logic [4:0]  PFC_STEP2     = 5'h02;
   localparam logic [4:0]  PFC_STEP3     = 5'h03;
   localparam logic [23:0] PFC_FRAC_MASK = 24'h00001F;
   localparam logic [23:0] PFC_ZERO24    = 24'h000000;
   localparam logic [4:0]  PFC_CNT_RST   = 5'h00;

   typedef enum logic [3:0] {
      PFC_ST_IDLE   = 4'b0001,
      PFC_ST_DECODE = 4'b0010,
      PFC_ST_FETCH  = 4'b0100,
      PFC_ST_CALC   = 4'b1000
   } pfc_state_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pfc_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } pfc_apb_rsp_s;

   typedef struct packed {
      logic        req;
      logic        space_x;
      logic [15:0] addr;
   } pfc_mem_req_s;

   typedef struct packed {
      logic        ack;
      logic [23:0] rdata;
   } pfc_mem_rsp_s;

endpackage
